// ### fmc_pkg.sv
package fmc_pkg;
  // Register byte addresses (printed offsets are not all word aligned)
  localparam logic [7:0] IDX_CONFIG = 8'h7F;
  localparam logic [7:0] IDX_SPEED_EN = 8'h80;
  localparam logic [7:0] IDX_PAIRING = 8'h81;
  localparam logic [7:0] IDX_SPECIAL = 8'hA0;
  localparam logic [7:0] IDX_STATUS = 8'hA1;
  localparam logic [7:0] IDX_STAT_CLR = 8'hA2;
  localparam logic [7:0] IDX_IRQ_EN = 8'hA3;
  localparam logic [7:0] IDX_FAN_CTRL = 8'hA4;
  localparam logic [7:0] IDX_LOCK = 8'hA5;
  // Reset values
  localparam logic [7:0] CONFIG_RST = 8'h10;
  localparam logic [7:0] SPEED_EN_RST = 8'h1E;
  localparam logic [7:0] PAIRING_RST = 8'hA4;
  localparam logic [7:0] SPECIAL_RST = 8'h00;
  localparam logic [7:0] FAN_CTRL_RST = 8'h0F;
  // Configuration field positions
  localparam int CFG_SPEED3_ALERT = 0;
  localparam int CFG_PWM2_ALERT = 1;
  localparam int CFG_TEMP_VALID = 3;
  localparam int CFG_SPINUP = 4;
  localparam int CFG_SOFT_RESET = 7;
  localparam int SPECIAL_GLOBAL_EN = 2;
  localparam int SPEED_EN_GROUP = 0;
  // Writable configuration bits (bit 3 is read-only)
  localparam logic [7:0] CONFIG_WMASK = 8'hF7;
  localparam logic [1:0] PAIR_PWM1 = 2'h0;
  localparam logic [1:0] PAIR_PWM2 = 2'h1;
  localparam logic [1:0] PAIR_PWM3 = 2'h2;
  localparam logic [15:0] MIN_LIMIT_OFF = 16'hFFFF;
  localparam int FANS = 4;
  localparam int PWMS = 3;
endpackage

// ### fmc_top.sv
`timescale 1ns/1ps
// Function
// - After lock is set, writes to configuration, speed enable and pairing registers are ignored.
// - Configuration bit 0 makes the shared pin speed input 3 when clear, alert output when set.
// - Configuration bit 1 makes the second shared pin PWM2 when clear, alert output when set.
// - Configuration bit 3 is read-only and reads one only when temperature readings are valid.
// - Configuration bit 4 resets to one and enables spin-up shortening from paired tachs.
// - Writing one to configuration bit 7 starts a soft reset and the bit clears itself.
// - Soft reset restores every register to default except the lock register and the live valid flag in configuration bit 3.
// - Speed enable bits 1 to 4 let each speed input set status bits and interrupts; reset set.
// - Speed enable bit 0 lets speed events pull alert low only with the global enable set.
// - Each speed input has a two-bit pairing field, 00 PWM1, 01 PWM2, 10 PWM3, 11 reserved.
// - No speed status bit is set while the paired PWM duty is zero.
// - No speed status bit is set while the fan is disabled.
// - No speed status bit is ever set for a fan whose minimum limit is all ones.
// - Special function bit 2 is the global alert enable; while clear no group drives alert.
module fmc_top (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Monitor side
  input wire logic TEMP_VALID_I,
  input wire logic [3:0] SPEED_LOW_I,
  input wire logic [7:0] DUTY1_I,
  input wire logic [7:0] DUTY2_I,
  input wire logic [7:0] DUTY3_I,
  input wire logic [63:0] MIN_LIMIT_I,
  input wire logic PWM2_I,
  input wire logic SPEED3_PIN_I,
  // Outputs
  output logic SPINUP_SHORTEN_O,
  output logic [2:0] PWM_SPEED_FEEDBACK_O,
  output logic SOFT_RESET_O,
  output logic FAN_SPEED_INPUT3_O,
  output logic SPEED3_PIN_O,
  output logic SPEED3_PIN_OE_O,
  output logic PWM2_PIN_O,
  output logic IRQ_O
);
  logic [7:0] config_r, config_nxt;
  logic [7:0] speed_en_r, speed_en_nxt;
  logic [7:0] pairing_r, pairing_nxt;
  logic [7:0] special_r, special_nxt;
  logic [3:0] status_r, status_nxt;
  logic [3:0] irq_en_r, irq_en_nxt;
  logic [3:0] fan_ctrl_r, fan_ctrl_nxt;
  logic lock_r, lock_nxt;
  logic soft_r, soft_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [1:0] tv_sync_r, tv_sync_nxt;
  logic [1:0] s3_sync_r, s3_sync_nxt;
  logic [3:0] low_s1_r, low_s2_r;
  logic [3:0] low_s1_nxt, low_s2_nxt;
  logic [3:0] qualified;
  logic [2:0] feedback;
  logic alert_n;
  logic wr, rd, wlane;
  logic [7:0] wbyte;
  logic [7:0] duty [0:2];

  assign duty[0] = DUTY1_I;
  assign duty[1] = DUTY2_I;
  assign duty[2] = DUTY3_I;
  assign wr = CYC_I && STB_I && WE_I && !ack_r;
  assign rd = CYC_I && STB_I && !WE_I && !ack_r;
  assign wlane = SEL_I[0];
  assign wbyte = DAT_I[7:0];

  // Per-fan qualification of a low-speed event
  genvar g;
  generate
    for (g = 0; g < fmc_pkg::FANS; g++) begin : g_fan
      logic [1:0] pair;
      logic pwm_idle;
      assign pair = pairing_r[2*g+1 -: 2];
      always_comb begin
        case (pair)
          fmc_pkg::PAIR_PWM1: pwm_idle = duty[0] == 8'h00;
          fmc_pkg::PAIR_PWM2: pwm_idle = duty[1] == 8'h00;
          fmc_pkg::PAIR_PWM3: pwm_idle = duty[2] == 8'h00;
          default: pwm_idle = 1'b1; // Reserved pairing reports nothing
        endcase
      end
      assign qualified[g] = low_s2_r[g] && speed_en_r[g+1]
        && !pwm_idle
        && fan_ctrl_r[g]
        && (MIN_LIMIT_I[16*g+15 -: 16] != fmc_pkg::MIN_LIMIT_OFF);
    end
  endgenerate

  // Tach feedback per PWM, used for spin-up shortening
  always_comb begin
    feedback = 3'h0;
    for (int f = 0; f < fmc_pkg::FANS; f++) begin
      if (pairing_r[2*f+1 -: 2] != 2'h3) begin
        feedback[pairing_r[2*f+1 -: 2]] = 1'b1;
      end
    end
  end

  // Alert: group enable and global enable must both be set
  assign alert_n = !(speed_en_r[fmc_pkg::SPEED_EN_GROUP]
    && special_r[fmc_pkg::SPECIAL_GLOBAL_EN] && (status_r != 4'h0));

  // Pin synchronisers; only the second stage is read by logic
  always_comb begin
    tv_sync_nxt = {tv_sync_r[0], TEMP_VALID_I};
    s3_sync_nxt = {s3_sync_r[0], SPEED3_PIN_I};
    low_s1_nxt = SPEED_LOW_I;
    low_s2_nxt = low_s1_r;
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      tv_sync_r <= 2'h0;
      // Idle level of the pulled-up pin, so no false low after reset
      s3_sync_r <= 2'h3;
      low_s1_r <= 4'h0;
      low_s2_r <= 4'h0;
    end else begin
      tv_sync_r <= tv_sync_nxt;
      s3_sync_r <= s3_sync_nxt;
      low_s1_r <= low_s1_nxt;
      low_s2_r <= low_s2_nxt;
    end
  end

  // Bus answer: one wait state, ack for exactly one cycle
  always_comb begin
    ack_nxt = rd || wr;
    dat_nxt = dat_r;
    if (rd) begin
      case (ADR_I)
        fmc_pkg::IDX_CONFIG: dat_nxt = {24'h0, config_r};
        fmc_pkg::IDX_SPEED_EN: dat_nxt = {24'h0, speed_en_r};
        fmc_pkg::IDX_PAIRING: dat_nxt = {24'h0, pairing_r};
        fmc_pkg::IDX_SPECIAL: dat_nxt = {24'h0, special_r};
        fmc_pkg::IDX_STATUS: dat_nxt = {28'h0, status_r};
        fmc_pkg::IDX_IRQ_EN: dat_nxt = {28'h0, irq_en_r};
        fmc_pkg::IDX_FAN_CTRL: dat_nxt = {28'h0, fan_ctrl_r};
        fmc_pkg::IDX_LOCK: dat_nxt = {31'h0, lock_r};
        default: dat_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // Soft reset pulse, launched at the edge that takes the write
  always_comb begin
    soft_nxt = 1'b0;
    if (wr && wlane && (ADR_I == fmc_pkg::IDX_CONFIG) && !lock_r) begin
      soft_nxt = wbyte[fmc_pkg::CFG_SOFT_RESET];
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      soft_r <= 1'b0;
    end else begin
      soft_r <= soft_nxt;
    end
  end

  // Status: set wins over a clear in the same cycle
  always_comb begin
    status_nxt = status_r;
    if (wr && wlane && (ADR_I == fmc_pkg::IDX_STAT_CLR)) begin
      status_nxt = status_r & ~wbyte[3:0];
    end
    if (soft_r) begin
      status_nxt = 4'h0;
    end
    status_nxt = status_nxt | qualified;
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      status_r <= 4'h0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Lock is set-only and survives soft reset, so it cannot be bypassed
  always_comb begin
    lock_nxt = lock_r;
    if (wr && wlane && (ADR_I == fmc_pkg::IDX_LOCK)) begin
      lock_nxt = lock_r | wbyte[0];
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      lock_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // Global alert enable
  always_comb begin
    special_nxt = special_r;
    if (wr && wlane && (ADR_I == fmc_pkg::IDX_SPECIAL)) begin
      special_nxt = wbyte;
    end
    if (soft_r) begin
      special_nxt = fmc_pkg::SPECIAL_RST;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      special_r <= fmc_pkg::SPECIAL_RST;
    end else begin
      special_r <= special_nxt;
    end
  end

  // Configuration and enables; lock freezes the first three
  always_comb begin
    config_nxt = config_r;
    speed_en_nxt = speed_en_r;
    pairing_nxt = pairing_r;
    irq_en_nxt = irq_en_r;
    fan_ctrl_nxt = fan_ctrl_r;
    config_nxt[fmc_pkg::CFG_TEMP_VALID] = tv_sync_r[1];
    config_nxt[fmc_pkg::CFG_SOFT_RESET] = 1'b0;
    if (wr && wlane) begin
      case (ADR_I)
        fmc_pkg::IDX_CONFIG: begin
          if (!lock_r) begin
            config_nxt = (wbyte & fmc_pkg::CONFIG_WMASK) |
              (config_nxt & ~fmc_pkg::CONFIG_WMASK);
            config_nxt[fmc_pkg::CFG_SOFT_RESET] = 1'b0;
          end
        end
        fmc_pkg::IDX_SPEED_EN: begin
          if (!lock_r) begin
            speed_en_nxt = {3'h0, wbyte[4:0]};
          end
        end
        fmc_pkg::IDX_PAIRING: begin
          if (!lock_r) begin
            pairing_nxt = wbyte;
          end
        end
        fmc_pkg::IDX_IRQ_EN: irq_en_nxt = wbyte[3:0];
        fmc_pkg::IDX_FAN_CTRL: fan_ctrl_nxt = wbyte[3:0];
        default: ;
      endcase
    end
    // Soft reset restores defaults but keeps the live valid flag
    if (soft_r) begin
      config_nxt = fmc_pkg::CONFIG_RST;
      config_nxt[fmc_pkg::CFG_TEMP_VALID] = tv_sync_r[1];
      speed_en_nxt = fmc_pkg::SPEED_EN_RST;
      pairing_nxt = fmc_pkg::PAIRING_RST;
      irq_en_nxt = 4'h0;
      fan_ctrl_nxt = fmc_pkg::FAN_CTRL_RST[3:0];
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      config_r <= fmc_pkg::CONFIG_RST;
      speed_en_r <= fmc_pkg::SPEED_EN_RST;
      pairing_r <= fmc_pkg::PAIRING_RST;
      irq_en_r <= 4'h0;
      fan_ctrl_r <= fmc_pkg::FAN_CTRL_RST[3:0];
    end else begin
      config_r <= config_nxt;
      speed_en_r <= speed_en_nxt;
      pairing_r <= pairing_nxt;
      irq_en_r <= irq_en_nxt;
      fan_ctrl_r <= fan_ctrl_nxt;
    end
  end

  assign DAT_O = dat_r;
  assign ACK_O = ack_r;
  assign SOFT_RESET_O = soft_r;
  assign SPINUP_SHORTEN_O = config_r[fmc_pkg::CFG_SPINUP];
  assign PWM_SPEED_FEEDBACK_O = config_r[fmc_pkg::CFG_SPINUP] ? feedback : 3'h0;
  // Shared pin as open-drain alert, or plain speed input
  assign SPEED3_PIN_O = 1'b0;
  assign SPEED3_PIN_OE_O = config_r[fmc_pkg::CFG_SPEED3_ALERT] && !alert_n;
  assign FAN_SPEED_INPUT3_O = config_r[fmc_pkg::CFG_SPEED3_ALERT] ? 1'b1 : s3_sync_r[1];
  assign PWM2_PIN_O = config_r[fmc_pkg::CFG_PWM2_ALERT] ? alert_n : PWM2_I;
  assign IRQ_O = |(status_r & irq_en_r);
endmodule // fmc_top

// ### fmc_checker.sv
`timescale 1ns/1ps
module fmc_checker (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Bus
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic CYC_I,
  input wire logic STB_I,
  // Monitor side
  input wire logic TEMP_VALID_I,
  input wire logic SPINUP_SHORTEN_O,
  input wire logic [2:0] PWM_SPEED_FEEDBACK_O,
  input wire logic SOFT_RESET_O,
  input wire logic SPEED3_PIN_O,
  input wire logic IRQ_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  wire logic rd_ack = ACK_O && !WE_I;
  wire logic init_wr = ACK_O && WE_I && ADR_I == 8'h7F && DAT_I[7];
  property p_ack_taken; CYC_I && STB_I && !ACK_O |=> ACK_O; endproperty
  a_ack_taken: assert property (p_ack_taken) else $error("ack missing");
  property p_ack_pulse; ACK_O |=> !ACK_O; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_rd_unmapped; rd_ack && ADR_I == 8'h10 |-> DAT_O == 32'h0; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_en_layout; rd_ack && ADR_I == 8'h80 |-> DAT_O[31:5] == 27'h0; endproperty
  a_en_layout: assert property (p_en_layout) else $error("enable upper bits set");
  // Six stable samples cover the synchroniser and the read register
  property p_cfg_valid;
    ($stable(TEMP_VALID_I))[*6] ##0 (rd_ack && ADR_I == 8'h7F) |-> DAT_O[3] == TEMP_VALID_I;
  endproperty
  a_cfg_valid: assert property (p_cfg_valid) else $error("valid flag wrong");
  property p_pin_low; !SPEED3_PIN_O; endproperty
  a_pin_low: assert property (p_pin_low) else $error("shared pin driven high");
  // Pulse and ack come from the same taking edge, so they are seen together
  property p_srst_cause; SOFT_RESET_O |-> init_wr; endproperty
  a_srst_cause: assert property (p_srst_cause) else $error("soft reset uncaused");
  property p_srst_pulse; SOFT_RESET_O |=> !SOFT_RESET_O; endproperty
  a_srst_pulse: assert property (p_srst_pulse) else $error("soft reset not cleared");
  property p_srst_dflt; SOFT_RESET_O |-> ##2 (SPINUP_SHORTEN_O && !IRQ_O && PWM_SPEED_FEEDBACK_O == 3'h7); endproperty
  a_srst_dflt: assert property (p_srst_dflt) else $error("defaults not restored");
  property p_fb_gate; !SPINUP_SHORTEN_O && !$past(SPINUP_SHORTEN_O) |-> PWM_SPEED_FEEDBACK_O == 3'h0; endproperty
  a_fb_gate: assert property (p_fb_gate) else $error("feedback not gated");
endmodule // fmc_checker

bind fmc_top fmc_checker fmc_checker_i (.CLK_I(CLK_I), .RESET_I(RESET_I), .WE_I(WE_I), .ADR_I(ADR_I),
  .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .CYC_I(CYC_I), .STB_I(STB_I), .TEMP_VALID_I(TEMP_VALID_I),
  .SPINUP_SHORTEN_O(SPINUP_SHORTEN_O), .PWM_SPEED_FEEDBACK_O(PWM_SPEED_FEEDBACK_O),
  .SOFT_RESET_O(SOFT_RESET_O), .SPEED3_PIN_O(SPEED3_PIN_O), .IRQ_O(IRQ_O));

// ### tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, tv = 1'b0, pwm2 = 1'b0, pin3 = 1'b1;
  logic [7:0] adr = 8'h00, d1 = 8'h80, d2 = 8'h80, d3 = 8'h80;
  logic [3:0] sel = 4'hF, low = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rv;
  logic [63:0] lim = 64'h0;
  logic ack, sus, srst, fin3, p3o, p3oe, p2o, irq;
  logic [2:0] fb;
  int failures = 0, num_checks = 0, nrst = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (srst === 1'b1) nrst++;
  fmc_top fmc_top_i (.CLK_I(clk), .RESET_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .TEMP_VALID_I(tv), .SPEED_LOW_I(low),
    .DUTY1_I(d1), .DUTY2_I(d2), .DUTY3_I(d3), .MIN_LIMIT_I(lim), .PWM2_I(pwm2), .SPEED3_PIN_I(pin3),
    .SPINUP_SHORTEN_O(sus), .PWM_SPEED_FEEDBACK_O(fb), .SOFT_RESET_O(srst), .FAN_SPEED_INPUT3_O(fin3),
    .SPEED3_PIN_O(p3o), .SPEED3_PIN_OE_O(p3oe), .PWM2_PIN_O(p2o), .IRQ_O(irq));
  task end_of_test;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic cycle; ack seen high at the edge ends it
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d};
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin failures++; end_of_test; end
    rv = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d); bus(1'b1, a, d); endtask
  task rd(input logic [7:0] a, input logic [31:0] e); bus(1'b0, a, 8'h00); chk(rv, e); endtask
  // Pulse fan events, check sticky status and level irq, then clear
  task evt(input logic [3:0] m, input logic [7:0] e, input logic q);
    low <= m; repeat (4) @(posedge clk); low <= 4'h0;
    rd(8'hA1, {24'h0, e}); chk(irq, q);
    wr(8'hA2, 8'h0F); chk(irq, 1'h0);
  endtask
  task t_reset;
    rd(8'h7F, 32'h10); chk(sus, 1'h1); chk(fb, 3'h7);
    rd(8'h80, 32'h1E); rd(8'h81, 32'hA4);
    rd(8'h10, 32'h0); rd(8'hA3, 32'h0); chk(p3oe, 1'h0); chk(fin3, 1'h1);
    $display("t_reset done");
  endtask
  task t_cfg;
    tv <= 1'b1; pwm2 <= 1'b1; repeat (4) @(posedge clk);
    wr(8'h7F, 8'h08); rd(8'h7F, 32'h08); chk(sus, 1'h0); chk(fb, 3'h0);
    chk(p2o, 1'h1);
    pin3 <= 1'b0; pwm2 <= 1'b0; wr(8'h7F, 8'h13);
    chk(fin3, 1'h1); chk(p2o, 1'h1);
    tv <= 1'b0; wr(8'h7F, 8'h00); rd(8'h7F, 32'h00); chk(fin3, 1'h0); chk(p2o, 1'h0);
    $display("t_cfg done");
  endtask
  task t_irq;
    wr(8'hA3, 8'h0F); evt(4'h1, 8'h01, 1'b1);
    d1 <= 8'h00; evt(4'h1, 8'h00, 1'b0);
    lim[31:16] <= 16'hFFFF; evt(4'h2, 8'h00, 1'b0); lim <= 64'h0;
    wr(8'hA4, 8'h0B); evt(4'h4, 8'h00, 1'b0); wr(8'hA4, 8'h0F);
    wr(8'h80, 8'h0E); evt(4'h8, 8'h00, 1'b0); evt(4'h4, 8'h04, 1'b1);
    wr(8'h81, 8'hA5); evt(4'h1, 8'h01, 1'b1);
    d3 <= 8'h00; wr(8'h81, 8'hA6); evt(4'h1, 8'h00, 1'b0); d3 <= 8'h80;
    wr(8'h81, 8'hA4); evt(4'h1, 8'h00, 1'b0); d1 <= 8'h80;
    wr(8'hA3, 8'h00); evt(4'h2, 8'h02, 1'b0);
    wr(8'h7F, 8'h11); wr(8'h80, 8'h1F); low <= 4'h2; repeat (4) @(posedge clk);
    chk(p3oe, 1'h0); wr(8'hA0, 8'h04); chk(p3oe, 1'h1);
    wr(8'h80, 8'h1E); chk(p3oe, 1'h0); low <= 4'h0;
    $display("t_irq done");
  endtask
  task t_srst;
    wr(8'h7F, 8'h80); repeat (2) @(posedge clk); chk(nrst, 32'h1);
    rd(8'h7F, 32'h10); rd(8'h80, 32'h1E); rd(8'h81, 32'hA4); rd(8'hA0, 32'h0);
    chk(p3oe, 1'h0); chk(irq, 1'h0);
    $display("t_srst done");
  endtask
  task t_lock;
    wr(8'hA5, 8'h01); wr(8'h7F, 8'h03); wr(8'h80, 8'h00); wr(8'h81, 8'h00);
    rd(8'h7F, 32'h10); rd(8'h80, 32'h1E); rd(8'h81, 32'hA4);
    wr(8'h7F, 8'h80); repeat (2) @(posedge clk); chk(nrst, 32'h1);
    $display("t_lock done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset; t_cfg; t_irq; t_srst; t_lock;
    end_of_test;
  end
endmodule // tb
